// >>> design/sepp_core.v
// Serial EEPROM SPI slave front end with write-cycle timer
`timescale 1ns/1ps
`include "sepp_defines.vh"

module sepp_core #(
  parameter ADDR_W = 9,
  parameter [19:0] WRITE_CYCLES = `SEPP_WRITE_CYCLES
) (
  input wire ref_clk_i,
  input wire sys_rst_i,
  input wire sclk_i,
  input wire sdi_i,
  input wire sel_n_i,
  input wire hold_n_i,
  input wire wp_n_i,
  output reg sdo_o,
  output reg sdo_oe_o,
  output reg standby_o,
  output reg [1:0] block_prot_o,
  output reg [ADDR_W-1:0] arr_addr_o,
  output reg arr_rd_o,
  input wire [7:0] arr_rdata_i,
  output reg arr_wr_o,
  output reg [7:0] arr_wdata_o
);

  // ****************************************
  // States, one-hot
  // ****************************************
  localparam [6:0] ST_CMD = 7'h01;
  localparam [6:0] ST_ADDR = 7'h02;
  localparam [6:0] ST_DATA = 7'h04;
  localparam [6:0] ST_RD = 7'h08;
  localparam [6:0] ST_SRO = 7'h10;
  localparam [6:0] ST_SRI = 7'h20;
  localparam [6:0] ST_WAIT = 7'h40;

  // ****************************************
  // Pin synchronisers
  // ****************************************
  reg [4:0] sync1; // First stage, read only by sync2
  reg [4:0] sync2; // Safe copies of the pins
  reg sclk_d; // Delayed clock for edge finding
  reg sel_d; // Delayed select for edge finding
  reg [2:0] fill; // Ones shift in while the synchronisers fill

  // Two flops per pin; the pins are asynchronous to ref_clk_i
  always @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      sync1 <= 5'h1c;
      sync2 <= 5'h1c;
      sclk_d <= 1'b0;
      sel_d <= 1'b1;
      fill <= 3'h0;
    end else begin
      fill <= {fill[1:0], 1'b1};
      sync1 <= {sel_n_i, hold_n_i, wp_n_i, sdi_i, sclk_i};
      sync2 <= sync1;
      sclk_d <= sync2[0];
      sel_d <= sync2[4];
    end
  end

  wire sclk_s = sync2[0];
  wire sdi_s = sync2[1];
  wire wp_n_s = sync2[2];
  wire hold_n_s = sync2[3];
  wire sel_n_s = sync2[4];

  // ****************************************
  // Protocol state
  // ****************************************
  reg [6:0] state; // Current protocol phase
  reg [2:0] bit_cnt; // Bit position in current byte
  reg [7:0] in_sh; // Input shift register
  reg [7:0] out_sh; // Output shift register
  reg armed; // Seen a select fall since reset
  reg hold_act; // Hold condition in force
  reg drv; // Output has started driving this frame
  reg is_read; // Address phase belongs to a read
  reg a8; // Top address bit from the opcode
  reg rd_pend; // Array data due next cycle
  reg permit; // Update permit latch
  reg [1:0] pend_latch; // Latch action at deselect: bit1 set, bit0 clr
  reg sr_ok; // Complete status byte waiting for deselect
  reg wr_ok; // Complete data byte waiting for deselect
  reg [7:0] sr_new; // Status value to commit
  reg [1:0] bp; // Block protect bits
  reg sr_top; // Top status bit, stored only
  reg busy; // Self-timed cycle running
  reg sr_cycle; // Running cycle is a status update
  reg [19:0] tmr; // Cycle countdown

  wire selected = ~sel_n_s;
  // Hold is only recognised while selected
  wire hold_now = selected & ~hold_n_s;
  // Clock edges count only when selected and not held
  wire live = selected & ~hold_act;
  wire rise = live & sclk_s & ~sclk_d;
  wire fall = live & ~sclk_s & sclk_d;
  // Reset fills the flops as deselected; a select held low from power-up
  // must not read as a fall, so edges count only once they hold pins
  wire sel_fall = ~sel_n_s & sel_d & fill[2];
  wire sel_rise = sel_n_s & ~sel_d;
  wire [7:0] byte_in = {in_sh[6:0], sdi_s};
  wire last_bit = (bit_cnt == 3'h7);
  wire op_hi_zero = (byte_in[7:4] == 4'h0);
  wire [2:0] op_lo = byte_in[2:0];
  // Both write instructions need the latch and an open protect pin
  wire wr_allowed = permit & wp_n_s;
  wire [7:0] status = {sr_top, 3'h0, bp, permit, busy};

  // ****************************************
  // Serial engine
  // ****************************************
  // Shifting, decoding and frame bookkeeping. A held frame keeps its
  // counters untouched, so it resumes exactly where it paused.
  always @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      state <= ST_CMD;
      bit_cnt <= 3'h0;
      in_sh <= 8'h00;
      out_sh <= 8'h00;
      armed <= 1'b0;
      hold_act <= 1'b0;
      drv <= 1'b0;
      is_read <= 1'b0;
      a8 <= 1'b0;
      rd_pend <= 1'b0;
      pend_latch <= 2'h0;
      sr_ok <= 1'b0;
      wr_ok <= 1'b0;
      sr_new <= 8'h00;
      arr_addr_o <= {ADDR_W{1'b0}};
      arr_rd_o <= 1'b0;
      arr_wdata_o <= 8'h00;
      sdo_o <= 1'b0;
    end else begin
      arr_rd_o <= 1'b0;
      rd_pend <= arr_rd_o;
      hold_act <= hold_now;
      // Arm on the first select fall after reset
      if (sel_fall) begin
        armed <= 1'b1;
      end
      if (!selected) begin
        // Deselected: frame restarts, output released
        state <= ST_CMD;
        bit_cnt <= 3'h0;
        drv <= 1'b0;
        sr_ok <= 1'b0;
        wr_ok <= 1'b0;
        pend_latch <= 2'h0;
      end else begin
        // Array byte arrives a cycle after the read strobe
        if (rd_pend) begin
          out_sh <= arr_rdata_i;
          arr_addr_o <= arr_addr_o + {{(ADDR_W-1){1'b0}}, 1'b1};
        end
        if (fall && (state == ST_RD || state == ST_SRO)) begin
          // New bit goes out only after a falling edge
          sdo_o <= out_sh[7];
          out_sh <= {out_sh[6:0], 1'b0};
          drv <= 1'b1;
        end
        if (rise) begin
          // Sample on rising edge
          in_sh <= byte_in;
          bit_cnt <= bit_cnt + 3'h1;
          case (state)
            ST_CMD: begin
              if (last_bit) begin
                state <= ST_WAIT;
                // Not armed, or busy with anything but a status read
                if (!armed || !op_hi_zero) begin
                  state <= ST_WAIT;
                end else if (op_lo == `SEPP_OP_STAT_RD) begin
                  // Status reachable only by its own opcode
                  state <= ST_SRO;
                  out_sh <= status;
                end else if (busy) begin
                  state <= ST_WAIT;
                end else if (op_lo == `SEPP_OP_PERMIT) begin
                  pend_latch <= 2'h2;
                end else if (op_lo == `SEPP_OP_REVOKE) begin
                  pend_latch <= 2'h1;
                end else if (op_lo == `SEPP_OP_STAT_UPD) begin
                  if (wr_allowed) begin
                    state <= ST_SRI;
                  end
                end else if (op_lo == `SEPP_OP_ARR_RD) begin
                  state <= ST_ADDR;
                  is_read <= 1'b1;
                  a8 <= byte_in[`SEPP_OP_A8_BIT];
                end else if (op_lo == `SEPP_OP_ARR_WR) begin
                  if (wr_allowed) begin
                    state <= ST_ADDR;
                    is_read <= 1'b0;
                    a8 <= byte_in[`SEPP_OP_A8_BIT];
                  end
                end
              end
            end
            ST_ADDR: begin
              if (last_bit) begin
                arr_addr_o <= {a8, byte_in};
                if (is_read) begin
                  state <= ST_RD;
                  arr_rd_o <= 1'b1;
                end else begin
                  state <= ST_DATA;
                end
              end
            end
            ST_DATA: begin
              // A started extra byte spoils the pending write
              if (last_bit) begin
                arr_wdata_o <= byte_in;
                wr_ok <= 1'b1;
              end else begin
                wr_ok <= 1'b0;
              end
            end
            ST_RD: begin
              // Fetch the next byte at every byte boundary; wraps
              if (last_bit) begin
                arr_rd_o <= 1'b1;
              end
            end
            ST_SRO: begin
              // Continuous status reads refresh the snapshot
              if (last_bit) begin
                out_sh <= status;
              end
            end
            ST_SRI: begin
              if (last_bit) begin
                sr_new <= byte_in;
                sr_ok <= 1'b1;
                state <= ST_WAIT;
              end
            end
            ST_WAIT: begin
              // Clock past the data byte cancels the update
              sr_ok <= 1'b0;
            end
            default: begin
              state <= ST_WAIT;
            end
          endcase
        end
      end
      // Output stays off while deselected or held
    end
  end

  // ****************************************
  // Latch, status and write-cycle timer
  // ****************************************
  // Cycles start at the deselect edge; the count runs on ref_clk_i so
  // its length does not depend on the host clock.
  always @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      permit <= 1'b0;
      bp <= `SEPP_BP_RST;
      sr_top <= `SEPP_TOP_RST;
      busy <= 1'b0;
      sr_cycle <= 1'b0;
      tmr <= 20'h00000;
      arr_wr_o <= 1'b0;
    end else begin
      arr_wr_o <= 1'b0;
      if (busy) begin
        // Protect pin is not looked at here
        if (tmr == 20'h00000) begin
          busy <= 1'b0;
          permit <= 1'b0;
          if (sr_cycle) begin
            // Protect bits take their new value only now
            bp <= sr_new[`SEPP_SR_BP_HI:`SEPP_SR_BP_LO];
            sr_top <= sr_new[`SEPP_SR_TOP];
          end
        end else begin
          tmr <= tmr - 20'h00001;
        end
      end else if (sel_rise && (sr_ok || wr_ok)) begin
        busy <= 1'b1;
        sr_cycle <= sr_ok;
        tmr <= WRITE_CYCLES - 20'h00001;
        arr_wr_o <= wr_ok;
      end else if (sel_rise && pend_latch[1]) begin
        permit <= 1'b1;
      end else if (sel_rise && pend_latch[0]) begin
        permit <= 1'b0;
      end
      // Protect pin low forces the latch clear, winning over a set
      if (!wp_n_s) begin
        permit <= 1'b0;
      end
    end
  end

  // ****************************************
  // Registered outputs
  // ****************************************
  // Drive only while selected, unheld and already started
  always @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      sdo_oe_o <= 1'b0;
      standby_o <= 1'b1;
      block_prot_o <= `SEPP_BP_RST;
    end else begin
      sdo_oe_o <= selected & ~hold_now & drv;
      // Active when selected; standby waits for the cycle
      standby_o <= ~selected & ~busy &
        ~(sel_rise & (sr_ok | wr_ok));
      block_prot_o <= bp;
    end
  end

endmodule

// >>> design/sepp_defines.vh
// Constants for the serial EEPROM pin-protocol front end
`ifndef SEPP_DEFINES_VH
`define SEPP_DEFINES_VH

// ****************************************
// Clock and timing
// ****************************************
`define SEPP_CLK_MHZ 100
`define SEPP_T_WRITE_US 5000
`define SEPP_WRITE_CYCLES 20'h7a120 // 5 ms of 100 MHz cycles

// ****************************************
// Instruction codes (upper nibble zero)
// ****************************************
`define SEPP_OP_PERMIT 3'h6
`define SEPP_OP_REVOKE 3'h4
`define SEPP_OP_STAT_RD 3'h5
`define SEPP_OP_STAT_UPD 3'h1
`define SEPP_OP_ARR_RD 3'h3
`define SEPP_OP_ARR_WR 3'h2
`define SEPP_OP_A8_BIT 3

// ****************************************
// Status byte layout and reset values
// ****************************************
`define SEPP_SR_BUSY 0
`define SEPP_SR_PERMIT 1
`define SEPP_SR_BP_LO 2
`define SEPP_SR_BP_HI 3
`define SEPP_SR_TOP 7
`define SEPP_BP_RST 2'h0
`define SEPP_TOP_RST 1'h0

`endif

// >>> testbench/sepp_chk.sv
// Checker of the serial EEPROM pin front end ports
`timescale 1ns/1ps
module sepp_chk (
  input wire ref_clk_i,
  input wire sys_rst_i,
  input wire sclk_i,
  input wire sel_n_i,
  input wire hold_n_i,
  input wire wp_n_i,
  input wire sdo_o,
  input wire sdo_oe_o,
  input wire standby_o,
  input wire arr_rd_o,
  input wire arr_wr_o
);
  // ****
  // Pin relations, allowing for the synchroniser delay
  // ****
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (sys_rst_i);
  AST_SEL_OFF: assert property (sel_n_i [*6] |-> !sdo_oe_o)
    else $error("output driven while deselected");
  AST_HOLD_OFF: assert property (!hold_n_i [*6] |-> !sdo_oe_o)
    else $error("output driven during hold");
  AST_ACTIVE: assert property (!sel_n_i [*6] |-> !standby_o)
    else $error("standby while selected");
  AST_WR_BUSY: assert property (arr_wr_o |-> ##2 !standby_o [*8])
    else $error("standby during write cycle");
  // Data may only move while the serial clock has been low
  AST_SDO_FALL: assert property ($changed(sdo_o) && sdo_oe_o |->
    !$past(sclk_i) && !$past(sclk_i, 2))
    else $error("output changed outside a falling edge");
  AST_WP_BLOCK: assert property (arr_wr_o |-> $past(wp_n_i, 6))
    else $error("array write under write protect");
  AST_OE_RISE: assert property ($rose(sdo_oe_o) |->
    !$past(sel_n_i, 3) && $past(hold_n_i, 3))
    else $error("output enabled while not selected or held");
  // Select reaches the strobe through two flops, hold through three
  AST_RD_SEL: assert property (arr_rd_o |->
    !$past(sel_n_i, 3) && $past(hold_n_i, 4))
    else $error("array read outside a live frame");
  COV_RD: cover property (arr_rd_o);
  COV_WR: cover property (arr_wr_o);
  COV_HOLD: cover property ($fell(sdo_oe_o) && !hold_n_i);
endmodule

bind sepp_core sepp_chk u_chk (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i),
  .sclk_i(sclk_i), .sel_n_i(sel_n_i), .hold_n_i(hold_n_i), .wp_n_i(wp_n_i),
  .sdo_o(sdo_o), .sdo_oe_o(sdo_oe_o), .standby_o(standby_o),
  .arr_rd_o(arr_rd_o), .arr_wr_o(arr_wr_o));

// >>> testbench/sepp_host.sv
// Host master model driving the serial pins
`timescale 1ns/1ps
module sepp_host (
  input wire ref_clk_i,
  input wire sdo_i,
  input wire sdo_oe_i,
  output logic sclk_o,
  output logic sdi_o,
  output logic sel_n_o,
  output logic hold_n_o
);
  logic last = 1'b0; // Last level the device drove
  // A released line never shows the old value
  wire line = sdo_oe_i ? sdo_i : ~last;
  // Select starts low so the unarmed case can be tried
  initial begin
    sclk_o = 1'b0;
    sdi_o = 1'b0;
    sel_n_o = 1'b0;
    hold_n_o = 1'b1;
  end
  always @(posedge ref_clk_i) begin
    if (sdo_oe_i) last <= sdo_i;
  end
  task automatic select;
    sel_n_o <= 1'b0;
    #100;
  endtask
  task automatic deselect;
    #100;
    sel_n_o <= 1'b1;
    sdi_o <= ~sdi_o;
    #300;
  endtask
  // One byte MSB first, mode 0; optional hold pause before bit hp
  task automatic xfer(input logic [7:0] tx, input int hp,
    output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      if (i == hp) begin
        hold_n_o <= 1'b0;
        sdi_o <= ~tx[i];
        #100 sclk_o <= 1'b1;
        #80 sclk_o <= 1'b0;
        #200 hold_n_o <= 1'b1;
        #100;
      end
      sdi_o <= tx[i];
      #80 sclk_o <= 1'b1;
      rx[i] = line;
      #80 sclk_o <= 1'b0;
    end
  endtask
endmodule

// >>> testbench/tb_top.sv
// Self-checking bench of the serial EEPROM pin front end
`timescale 1ns/1ps
`include "sepp_defines.vh"
module tb_top;
  localparam WC = 400; // Write time cut to 4 us to keep the run short
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic wp_n = 1'b1;
  logic [7:0] rdata = 8'h00;
  wire sclk, sdi, sel_n, hold_n, sdo, oe, stby, rd, wr;
  wire [1:0] bp;
  wire [8:0] addr;
  wire [7:0] wdata;
  logic [7:0] mem [0:511]; // Array stand-in
  logic [7:0] rx;
  logic [8:0] a;
  int err_total = 0;
  int checked = 0;
  int n_rd = 0;
  int n_wr = 0;
  int cyc = 0;
  int w0;
  // Rows: address and data written, then expected on read-back
  logic [16:0] rows [3] = '{{9'h000, 8'ha5}, {9'h1ff, 8'h3c},
    {9'h123, 8'h5a}};
  sepp_core #(.WRITE_CYCLES(20'(WC))) DUT (.ref_clk_i(clk),
    .sys_rst_i(rst), .sclk_i(sclk), .sdi_i(sdi), .sel_n_i(sel_n),
    .hold_n_i(hold_n), .wp_n_i(wp_n), .sdo_o(sdo), .sdo_oe_o(oe),
    .standby_o(stby), .block_prot_o(bp), .arr_addr_o(addr),
    .arr_rd_o(rd), .arr_rdata_i(rdata), .arr_wr_o(wr),
    .arr_wdata_o(wdata));
  sepp_host u_host (.ref_clk_i(clk), .sdo_i(sdo), .sdo_oe_i(oe),
    .sclk_o(sclk), .sdi_o(sdi), .sel_n_o(sel_n), .hold_n_o(hold_n));
  initial begin
    forever #5 clk = ~clk;
  end
  // Array model; a hang is cut short by the cycle ceiling
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (rd) begin
      rdata <= mem[addr];
      n_rd <= n_rd + 1;
    end
    if (wr) begin
      mem[addr] <= wdata;
      n_wr <= n_wr + 1;
    end
    if (cyc == 40000) begin
      err_total++;
      print_verdict;
    end
  end
  task automatic chk8(input string n, input logic [7:0] e,
    input logic [7:0] g);
    checked++;
    if (g !== e) begin
      err_total++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic chkb(input string n, input logic e, input logic g);
    chk8(n, {7'h0, e}, {7'h0, g});
  endtask
  // One whole frame: opcode, up to two bytes, last byte received
  task automatic run(input logic [7:0] op, input int nb,
    input logic [7:0] b1, input logic [7:0] b2, output logic [7:0] q);
    u_host.select;
    u_host.xfer(op, -1, q);
    if (nb > 0) u_host.xfer(b1, -1, q);
    if (nb > 1) u_host.xfer(b2, -1, q);
    u_host.deselect;
  endtask
  task automatic print_verdict;
    if (err_total == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    u_host.xfer({4'h0, 1'b0, `SEPP_OP_ARR_RD}, -1, rx);
    u_host.xfer(8'h10, -1, rx);
    u_host.xfer(8'h00, -1, rx);
    u_host.deselect;
    chkb("unarmed read", 1'b1, n_rd == 0);
    run(8'h05, 1, 8'h00, 8'h00, rx);
    chk8("status at reset", 8'h00, rx);
    foreach (rows[i]) begin
      a = rows[i][16:8];
      run(8'h06, 0, 8'h00, 8'h00, rx);
      run({4'h0, a[8], `SEPP_OP_ARR_WR}, 2, a[7:0], rows[i][7:0], rx);
      chkb("standby in write", 1'b0, stby);
      run(8'h05, 1, 8'h00, 8'h00, rx);
      chk8("status in write", 8'h03, rx);
      repeat (WC) @(posedge clk);
      chkb("standby after write", 1'b1, stby);
      run(8'h05, 1, 8'h00, 8'h00, rx);
      chk8("status after write", 8'h00, rx);
      run({4'h0, a[8], `SEPP_OP_ARR_RD}, 2, a[7:0], 8'h00, rx);
      chk8("read back", rows[i][7:0], rx);
    end
    // Read across the top address, with a hold in mid-byte
    u_host.select;
    u_host.xfer({4'h0, 1'b1, `SEPP_OP_ARR_RD}, -1, rx);
    u_host.xfer(8'hff, -1, rx);
    u_host.xfer(8'h00, -1, rx);
    u_host.xfer(8'h00, 4, rx);
    chk8("wrap and hold", 8'ha5, rx);
    u_host.deselect;
    // Write protect low: latch cleared, both writes refused
    w0 = n_wr;
    @(posedge clk) wp_n <= 1'b0;
    run(8'h06, 0, 8'h00, 8'h00, rx);
    run(8'h05, 1, 8'h00, 8'h00, rx);
    chk8("latch under protect", 8'h00, rx);
    run({4'h0, 1'b0, `SEPP_OP_ARR_WR}, 2, 8'h10, 8'h77, rx);
    run(8'h01, 1, 8'hfc, 8'h00, rx);
    chkb("write refused", 1'b1, n_wr == w0);
    chk8("status update refused", 8'h00, {6'h0, bp});
    @(posedge clk) wp_n <= 1'b1;
    // Permit then revoke: write must be dropped
    run(8'h06, 0, 8'h00, 8'h00, rx);
    run(8'h04, 0, 8'h00, 8'h00, rx);
    run({4'h0, 1'b0, `SEPP_OP_ARR_WR}, 2, 8'h30, 8'h11, rx);
    chkb("revoked write", 1'b1, n_wr == w0);
    run(8'h06, 0, 8'h00, 8'h00, rx);
    run(8'h01, 1, 8'hfc, 8'h00, rx);
    repeat (WC + 20) @(posedge clk);
    chk8("protect bits", 8'h03, {6'h0, bp});
    run(8'h05, 1, 8'h00, 8'h00, rx);
    chk8("status after update", 8'h8c, rx);
    // Protect lowered during a running write must not stop it
    run(8'h06, 0, 8'h00, 8'h00, rx);
    run({4'h0, 1'b0, `SEPP_OP_ARR_WR}, 2, 8'h20, 8'h5a, rx);
    @(posedge clk) wp_n <= 1'b0;
    run(8'h05, 1, 8'h00, 8'h00, rx);
    chkb("busy under protect", 1'b1, rx[0]);
    repeat (WC) @(posedge clk);
    wp_n <= 1'b1;
    run({4'h0, 1'b0, `SEPP_OP_ARR_RD}, 2, 8'h20, 8'h00, rx);
    chk8("write completed", 8'h5a, rx);
    print_verdict;
  end
endmodule
